/* File: common/tcu_pkg.sv */
// tcu_pkg: register map, field positions, reset values and
// mode encoding of the three-channel timer/counter unit.
// assumes a 12-bit AXI4-Lite byte address and 32-bit data.
`default_nettype none
package tcu_pkg;
  // ------------------------------------------------------------
  // bus windows and answers
  // ------------------------------------------------------------
  localparam int ADDR_W = 12;
  localparam logic [1:0] WIN_BYTE = 2'h0; // byte regs at 4 * index
  localparam logic [1:0] WIN_BIT = 2'h1; // 0x400 + 4 * bit address
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ------------------------------------------------------------
  // register indices (byte address is four times the index)
  // ------------------------------------------------------------
  localparam logic [7:0] IDX_CTL = 8'h88;
  localparam logic [7:0] IDX_MOD = 8'h89;
  localparam logic [7:0] IDX_T2C = 8'hC8;
  localparam logic [7:0] IDX_CAP_LO = 8'hCA;
  localparam logic [7:0] IDX_CAP_HI = 8'hCB;
  localparam logic [7:0] IDX_STAT = 8'hE0;
  localparam logic [7:0] IDX_MASK = 8'hE1;
  // count bytes of channels two, one, zero
  localparam logic [2:0][7:0] IDX_LO = {8'hCC, 8'h8B, 8'h8A};
  localparam logic [2:0][7:0] IDX_HI = {8'hCD, 8'h8D, 8'h8C};

  // ------------------------------------------------------------
  // field positions
  // ------------------------------------------------------------
  localparam int CTL_OVF_ONE = 7;
  localparam int CTL_RUN_ONE = 6;
  localparam int CTL_OVF_ZERO = 5;
  localparam int CTL_RUN_ZERO = 4;
  localparam int MOD_GATE_ONE = 7;
  localparam int MOD_SRC_ONE = 6;
  localparam int MOD_MODE_ONE = 4;
  localparam int MOD_GATE_ZERO = 3;
  localparam int MOD_SRC_ZERO = 2;
  localparam int MOD_MODE_ZERO = 0;
  localparam int T2C_OVF = 7;
  localparam int T2C_RUN = 2;
  localparam int T2C_SRC = 1;
  localparam int IRQ_W = 3;

  // ------------------------------------------------------------
  // reset values
  // ------------------------------------------------------------
  localparam logic [7:0] CTL_RST = 8'h00;
  localparam logic [7:0] MOD_RST = 8'h00;
  localparam logic [7:0] T2C_RST = 8'h00;
  localparam logic [7:0] CNT_RST = 8'h00;
  localparam logic [IRQ_W-1:0] IRQ_RST = 3'h0;

  // counting modes of channels zero and one
  typedef enum logic [1:0] {
    TCU_M_PRESC,
    TCU_M_CASC,
    TCU_M_RELOAD,
    TCU_M_SPLIT
  } tcu_mode_t;
endpackage
`default_nettype wire

/* File: src/tcu_fall_det.sv */
// tcu_fall_det: per-channel falling edge finder for count inputs.
// assumes the inputs are synchronous to aclk.
`default_nettype none
module tcu_fall_det #(
  parameter int N_CH = 3
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [N_CH-1:0] count_in,
  output logic [N_CH-1:0] fall
);
  // ------------------------------------------------------------
  // elaboration check
  // ------------------------------------------------------------
  if (N_CH < 1) begin : g_chk
    $error("tcu_fall_det needs at least one channel");
  end

  // ------------------------------------------------------------
  // sample and compare, one channel per loop step
  // ------------------------------------------------------------
  for (genvar g = 0; g < N_CH; g++) begin : g_ch
    logic smp_r;
    logic fall_r;
    // high sample then low sample gives one pulse
    // levels shorter than a cycle may be missed
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        smp_r <= 1'b0;
        fall_r <= 1'b0;
      end else begin
        smp_r <= count_in[g];
        fall_r <= smp_r & ~count_in[g];
      end
    end
    assign fall[g] = fall_r;

    property p_fall;
      @(posedge aclk) disable iff (!aresetn)
      fall[g] |-> $past(count_in[g], 2) && !$past(count_in[g]);
    endproperty
    a_fall: assert property (p_fall)
      else $error("count pulse without a falling edge");

    property p_fall_gap;
      @(posedge aclk) disable iff (!aresetn)
      fall[g] |=> !fall[g];
    endproperty
    a_fall_gap: assert property (p_fall_gap)
      else $error("count pulses faster than half the clock");
  end
endmodule
`default_nettype wire

/* File: src/tcu_timer_unit.sv */
// tcu_timer_unit: three 16-bit timer/counters behind AXI4-Lite.
// assumes count and interrupt pins synchronous to aclk, and a core
// that pulses the vector acknowledges when it enters a handler.
//
// Summary of operation
// - three 16-bit timer/counters, each a high and a low byte
// - timer mode: low byte steps once per clock cycle
// - counter mode: step on a high sample followed by a low one
// - edge needs two cycles, so counting runs at half clock max
// - gate one set: channel one runs only while its pin is high
// - gate zero set: channel zero runs only while its pin is high
// - source bit one picks pin edges when set, clock when clear
// - mode 00: 5-bit prescaler low byte feeding 8-bit high byte
// - mode 01: high and low cascaded, 16 bits, no prescaler
// - mode 10: 8-bit low byte reloaded from high on overflow
// - channel one mode 11: stopped, value held
// - control registers bit addressable, the rest bytes only
// - channel two has a 16-bit reload register pair
// - overflow sets the flag; vector acknowledge clears it on channels zero and one
// - run bits start and stop channels zero and one
// - channel zero has its own source bit and mode field
// - zero mode 11: low byte on zero controls, high on one's
`default_nettype none
module tcu_timer_unit (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic count_input_zero,
  input wire logic count_input_one,
  input wire logic count_input_two,
  input wire logic ext_irq_zero_pin,
  input wire logic ext_irq_one_pin,
  input wire logic timer_zero_vector_ack,
  input wire logic timer_one_vector_ack,
  input wire logic [tcu_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [tcu_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic timer_zero_overflow_flag,
  output logic timer_one_overflow_flag,
  output logic irq
);
  import tcu_pkg::*;

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  logic [7:0] ctl_r, ctl_nxt;
  logic [7:0] mod_r;
  logic [7:0] t2c_r, t2c_nxt;
  logic [7:0] cap_lo_r, cap_hi_r;
  logic [2:0][7:0] lo_r, hi_r;
  logic [2:0][7:0] lo_nxt, hi_nxt;
  logic [IRQ_W-1:0] stat_r, stat_nxt, mask_r, mask_nxt;
  logic irq_r;
  logic awrdy_r, wrdy_r, bval_r, arrdy_r, rval_r;
  logic [1:0] bresp_r, rresp_r;
  logic [31:0] rdata_r;
  logic [ADDR_W-1:0] wa_r;
  logic [31:0] wd_r;
  logic ws_r;
  // decode and counting nets
  logic wr_go, wr_en, w_hit, rd_hit;
  logic [7:0] w_idx, r_idx, wv, rd_v;
  logic we_ctl, we_mod, we_t2c, we_cl, we_ch, we_st, we_mk;
  logic [2:0] we_lo, we_hi, wr_t;
  logic [2:0] fall, run, inc, ovf;
  logic [16:0] st0, st1;
  logic [15:0] cnt0, cnt1, cnt2;
  tcu_mode_t m0, m1;

  // ------------------------------------------------------------
  // count input edges
  // ------------------------------------------------------------
  tcu_fall_det #(
    .N_CH(3)
  ) u_fall (
    .aclk(aclk),
    .aresetn(aresetn),
    .count_in({count_input_two, count_input_one, count_input_zero}),
    .fall(fall)
  );

  // ------------------------------------------------------------
  // one counting step for modes 00, 01, 10 and stop
  // ------------------------------------------------------------
  // result is {overflow, high, low}
  function automatic logic [16:0] step(input tcu_mode_t m,
    input logic [7:0] h, input logic [7:0] l, input logic en);
    logic [16:0] r;
    r = {1'b0, h, l};
    if (en) begin
      case (m)
        TCU_M_PRESC: begin // 13 bits
          r[4:0] = l[4:0] + 5'h01;
          if (l[4:0] == 5'h1F) begin
            r[16:8] = {1'b0, h} + 9'h001;
          end
        end
        TCU_M_CASC: begin // 16 bits
          r = {1'b0, h, l} + 17'h00001;
        end
        TCU_M_RELOAD: begin
          if (l == 8'hFF) begin
            r = {1'b1, h, h};
          end else begin
            r[7:0] = l + 8'h01;
          end
        end
        default: begin // held
          r = {1'b0, h, l};
        end
      endcase
    end
    return r;
  endfunction

  // ------------------------------------------------------------
  // run gating, source selection and counting
  // ------------------------------------------------------------
  assign m0 = tcu_mode_t'(mod_r[MOD_MODE_ZERO +: 2]);
  assign m1 = tcu_mode_t'(mod_r[MOD_MODE_ONE +: 2]);
  assign cnt0 = {hi_r[0], lo_r[0]};
  assign cnt1 = {hi_r[1], lo_r[1]};
  assign cnt2 = {hi_r[2], lo_r[2]};

  // run bit plus optional pin gate
  always_comb begin
    run[0] = ctl_r[CTL_RUN_ZERO]
      & (~mod_r[MOD_GATE_ZERO] | ext_irq_zero_pin);
    run[1] = ctl_r[CTL_RUN_ONE]
      & (~mod_r[MOD_GATE_ONE] | ext_irq_one_pin);
    run[2] = t2c_r[T2C_RUN];
    // clock cycle or pin edge
    inc[0] = run[0] & (mod_r[MOD_SRC_ZERO] ? fall[0] : 1'b1);
    inc[1] = run[1] & (mod_r[MOD_SRC_ONE] ? fall[1] : 1'b1);
    inc[2] = run[2] & (t2c_r[T2C_SRC] ? fall[2] : 1'b1);
  end

  // next counts and overflow events of all channels
  always_comb begin
    st0 = step(m0, hi_r[0], lo_r[0], inc[0]);
    st1 = step(m1, hi_r[1], lo_r[1], inc[1]);
    lo_nxt = lo_r;
    hi_nxt = hi_r;
    ovf = 3'h0;
    {hi_nxt[1], lo_nxt[1]} = st1[15:0];
    if (m0 == TCU_M_SPLIT) begin
      lo_nxt[0] = lo_r[0] + {7'h00, inc[0]};
      ovf[0] = inc[0] & (lo_r[0] == 8'hFF);
      hi_nxt[0] = hi_r[0] + {7'h00, run[1]};
      ovf[1] = run[1] & (hi_r[0] == 8'hFF);
    end else begin
      {hi_nxt[0], lo_nxt[0]} = st0[15:0];
      ovf[0] = st0[16];
      ovf[1] = st1[16];
    end
    // channel two: 16 bits with reload from the pair
    if (inc[2]) begin
      if (cnt2 == 16'hFFFF) begin
        {hi_nxt[2], lo_nxt[2]} = {cap_hi_r, cap_lo_r};
        ovf[2] = 1'b1;
      end else begin
        {hi_nxt[2], lo_nxt[2]} = cnt2 + 16'h0001;
      end
    end
  end

  // ------------------------------------------------------------
  // write decode
  // ------------------------------------------------------------
  assign wr_go = ~awrdy_r & ~wrdy_r & ~bval_r;
  assign wr_en = wr_go & ws_r;
  assign w_idx = wa_r[9:2];
  assign wr_t = we_lo | we_hi;

  // bit window only reaches the two control registers
  always_comb begin
    w_hit = 1'b0;
    wv = wd_r[7:0];
    {we_ctl, we_mod, we_t2c, we_cl, we_ch, we_st, we_mk} = 7'h00;
    we_lo = 3'h0;
    we_hi = 3'h0;
    if (wa_r[11:10] == WIN_BIT) begin
      if (w_idx[7:3] == IDX_CTL[7:3]) begin
        w_hit = 1'b1;
        wv = ctl_r;
        wv[w_idx[2:0]] = wd_r[0];
        we_ctl = wr_en;
      end else if (w_idx[7:3] == IDX_T2C[7:3]) begin
        w_hit = 1'b1;
        wv = t2c_r;
        wv[w_idx[2:0]] = wd_r[0];
        we_t2c = wr_en;
      end
    end else if (wa_r[11:10] == WIN_BYTE) begin
      w_hit = 1'b1;
      if (w_idx == IDX_CTL) begin
        we_ctl = wr_en;
      end else if (w_idx == IDX_MOD) begin
        we_mod = wr_en;
      end else if (w_idx == IDX_T2C) begin
        we_t2c = wr_en;
      end else if (w_idx == IDX_CAP_LO) begin
        we_cl = wr_en;
      end else if (w_idx == IDX_CAP_HI) begin
        we_ch = wr_en;
      end else if (w_idx == IDX_STAT) begin
        we_st = wr_en;
      end else if (w_idx == IDX_MASK) begin
        we_mk = wr_en;
      end else begin
        w_hit = 1'b0;
      end
      for (int i = 0; i < 3; i++) begin
        if (w_idx == IDX_LO[i]) begin
          w_hit = 1'b1;
          we_lo[i] = wr_en;
        end
        if (w_idx == IDX_HI[i]) begin
          w_hit = 1'b1;
          we_hi[i] = wr_en;
        end
      end
    end
  end

  // ------------------------------------------------------------
  // read decode
  // ------------------------------------------------------------
  assign r_idx = s_axi_araddr[9:2];

  // single bits of the control registers
  always_comb begin
    rd_v = 8'h00;
    rd_hit = 1'b1;
    if (s_axi_araddr[11:10] == WIN_BIT) begin
      if (r_idx[7:3] == IDX_CTL[7:3]) begin
        rd_v = {7'h00, ctl_r[r_idx[2:0]]};
      end else if (r_idx[7:3] == IDX_T2C[7:3]) begin
        rd_v = {7'h00, t2c_r[r_idx[2:0]]};
      end else begin
        rd_hit = 1'b0;
      end
    end else if (s_axi_araddr[11:10] == WIN_BYTE) begin
      if (r_idx == IDX_CTL) begin
        rd_v = ctl_r;
      end else if (r_idx == IDX_MOD) begin
        rd_v = mod_r;
      end else if (r_idx == IDX_T2C) begin
        rd_v = t2c_r;
      end else if (r_idx == IDX_CAP_LO) begin
        rd_v = cap_lo_r;
      end else if (r_idx == IDX_CAP_HI) begin
        rd_v = cap_hi_r;
      end else if (r_idx == IDX_STAT) begin
        rd_v = {5'h00, stat_r};
      end else if (r_idx == IDX_MASK) begin
        rd_v = {5'h00, mask_r};
      end else begin
        rd_hit = 1'b0;
      end
      for (int i = 0; i < 3; i++) begin
        if (r_idx == IDX_LO[i]) begin
          rd_v = lo_r[i];
          rd_hit = 1'b1;
        end
        if (r_idx == IDX_HI[i]) begin
          rd_v = hi_r[i];
          rd_hit = 1'b1;
        end
      end
    end else begin
      rd_hit = 1'b0;
    end
  end

  // ------------------------------------------------------------
  // flags: set wins over acknowledge and over software clear
  // ------------------------------------------------------------
  always_comb begin
    ctl_nxt = ctl_r;
    if (timer_zero_vector_ack) begin
      ctl_nxt[CTL_OVF_ZERO] = 1'b0;
    end
    if (timer_one_vector_ack) begin
      ctl_nxt[CTL_OVF_ONE] = 1'b0;
    end
    if (we_ctl) begin
      ctl_nxt = wv;
    end
    // hardware set of overflow flags
    ctl_nxt[CTL_OVF_ZERO] = ctl_nxt[CTL_OVF_ZERO] | ovf[0];
    ctl_nxt[CTL_OVF_ONE] = ctl_nxt[CTL_OVF_ONE] | ovf[1];
    t2c_nxt = we_t2c ? wv : t2c_r;
    t2c_nxt[T2C_OVF] = t2c_nxt[T2C_OVF] | ovf[2];
    stat_nxt = (we_st ? stat_r & ~wv[2:0] : stat_r) | ovf;
    mask_nxt = we_mk ? wv[2:0] : mask_r;
  end

  // control, mode and interrupt registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctl_r <= CTL_RST;
      mod_r <= MOD_RST;
      t2c_r <= T2C_RST;
      stat_r <= IRQ_RST;
      mask_r <= IRQ_RST;
      irq_r <= 1'b0;
    end else begin
      ctl_r <= ctl_nxt;
      mod_r <= we_mod ? wv : mod_r;
      t2c_r <= t2c_nxt;
      stat_r <= stat_nxt;
      mask_r <= mask_nxt;
      irq_r <= |(stat_nxt & mask_nxt);
    end
  end

  // count and reload bytes; a software write beats the count
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      lo_r <= {3{CNT_RST}};
      hi_r <= {3{CNT_RST}};
      cap_lo_r <= CNT_RST;
      cap_hi_r <= CNT_RST;
    end else begin
      for (int i = 0; i < 3; i++) begin
        lo_r[i] <= we_lo[i] ? wv : lo_nxt[i];
        hi_r[i] <= we_hi[i] ? wv : hi_nxt[i];
      end
      cap_lo_r <= we_cl ? wv : cap_lo_r;
      cap_hi_r <= we_ch ? wv : cap_hi_r;
    end
  end

  // ------------------------------------------------------------
  // AXI4-Lite write channels
  // ------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awrdy_r <= 1'b1;
      wa_r <= '0;
    end else if (s_axi_awvalid && awrdy_r) begin
      awrdy_r <= 1'b0;
      wa_r <= s_axi_awaddr;
    end else if (bval_r && s_axi_bready) begin
      awrdy_r <= 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wrdy_r <= 1'b1;
      wd_r <= 32'h0000_0000;
      ws_r <= 1'b0;
    end else if (s_axi_wvalid && wrdy_r) begin
      wrdy_r <= 1'b0;
      wd_r <= s_axi_wdata;
      ws_r <= s_axi_wstrb[0];
    end else if (bval_r && s_axi_bready) begin
      wrdy_r <= 1'b1;
    end
  end

  // response one cycle after both halves are held
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bval_r <= 1'b0;
      bresp_r <= RESP_OKAY;
    end else if (wr_go) begin
      bval_r <= 1'b1;
      bresp_r <= w_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (bval_r && s_axi_bready) begin
      bval_r <= 1'b0;
    end
  end

  // ------------------------------------------------------------
  // AXI4-Lite read channels
  // ------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arrdy_r <= 1'b1;
      rval_r <= 1'b0;
      rdata_r <= 32'h0000_0000;
      rresp_r <= RESP_OKAY;
    end else if (s_axi_arvalid && arrdy_r) begin
      arrdy_r <= 1'b0;
      rval_r <= 1'b1;
      rdata_r <= {24'h00_0000, rd_v};
      rresp_r <= rd_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (rval_r && s_axi_rready) begin
      arrdy_r <= 1'b1;
      rval_r <= 1'b0;
    end
  end

  // outputs straight from flip-flops
  assign s_axi_awready = awrdy_r;
  assign s_axi_wready = wrdy_r;
  assign s_axi_bvalid = bval_r;
  assign s_axi_bresp = bresp_r;
  assign s_axi_arready = arrdy_r;
  assign s_axi_rvalid = rval_r;
  assign s_axi_rdata = rdata_r;
  assign s_axi_rresp = rresp_r;
  assign timer_zero_overflow_flag = ctl_r[CTL_OVF_ZERO];
  assign timer_one_overflow_flag = ctl_r[CTL_OVF_ONE];
  assign irq = irq_r;

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  property p_cascade;
    (m0 == TCU_M_CASC && !mod_r[MOD_SRC_ZERO] && run[0] && !wr_t[0])
      |=> cnt0 == $past(cnt0) + 16'h0001;
  endproperty
  a_cascade: assert property (p_cascade)
    else $error("cascaded count did not step each cycle");

  property p_stop;
    (m1 == TCU_M_SPLIT && !wr_t[1]) |=> $stable(cnt1);
  endproperty
  a_stop: assert property (p_stop)
    else $error("stopped channel one changed");

  property p_timer_zero_gate_enable;
    (mod_r[MOD_GATE_ZERO] && !ext_irq_zero_pin && !wr_t[0]
      && m0 != TCU_M_SPLIT) |=> $stable(cnt0);
  endproperty
  a_timer_zero_gate_enable: assert property (p_timer_zero_gate_enable)
    else $error("channel zero counted with its gate pin low");

  property p_timer_one_gate_enable;
    (mod_r[MOD_GATE_ONE] && !ext_irq_one_pin && !wr_t[1])
      |=> $stable(cnt1);
  endproperty
  a_timer_one_gate_enable: assert property (p_timer_one_gate_enable)
    else $error("channel one counted with its gate pin low");

  property p_run;
    (!ctl_r[CTL_RUN_ZERO] && !wr_t[0] && m0 != TCU_M_SPLIT) ##1
      (!ctl_r[CTL_RUN_ZERO] && !wr_t[0] && m0 != TCU_M_SPLIT)
      |-> $stable(cnt0) [*2];
  endproperty
  a_run: assert property (p_run)
    else $error("channel zero counted with run bit clear");

  property p_reload;
    (m0 == TCU_M_RELOAD && inc[0] && lo_r[0] == 8'hFF && !wr_t[0])
      |=> lo_r[0] == $past(hi_r[0]) && ctl_r[CTL_OVF_ZERO];
  endproperty
  a_reload: assert property (p_reload)
    else $error("low byte not reloaded on overflow");

  property p_presc;
    (m0 == TCU_M_PRESC && inc[0] && lo_r[0][4:0] != 5'h1F
      && !wr_t[0]) |=> $stable(hi_r[0]);
  endproperty
  a_presc: assert property (p_presc)
    else $error("high byte stepped before prescaler wrapped");

  property p_ovf;
    (m0 == TCU_M_CASC && inc[0] && cnt0 == 16'hFFFF)
      |=> ctl_r[CTL_OVF_ZERO] && stat_r[0]
      ##1 (stat_r[0] || $past(we_st && wv[0]));
  endproperty
  a_ovf: assert property (p_ovf)
    else $error("16-bit rollover did not raise the flag");

  property p_ack;
    (timer_zero_vector_ack && !ovf[0] && !we_ctl)
      |=> !ctl_r[CTL_OVF_ZERO];
  endproperty
  a_ack: assert property (p_ack)
    else $error("vector acknowledge did not clear the flag");

  property p_split;
    (m0 == TCU_M_SPLIT && run[1] && !wr_t[0])
      |=> hi_r[0] == $past(hi_r[0]) + 8'h01;
  endproperty
  a_split: assert property (p_split)
    else $error("split high byte not run by channel one controls");

  property p_reload2;
    (inc[2] && cnt2 == 16'hFFFF && !wr_t[2] && !we_cl && !we_ch)
      |=> cnt2 == {cap_hi_r, cap_lo_r};
  endproperty
  a_reload2: assert property (p_reload2)
    else $error("channel two not reloaded from its pair");

  c_ovf0: cover property (ovf[0] && m0 == TCU_M_CASC);
  c_ovf1: cover property (ovf[1] && m0 == TCU_M_SPLIT);
  c_reload: cover property (ovf[0] && m0 == TCU_M_RELOAD);
  c_bitwr: cover property (we_ctl && wa_r[11:10] == WIN_BIT);
endmodule
`default_nettype wire

/* File: verif/tcu_pin_src.sv */
// tcu_pin_src: outside source of count pulses on one pin.
// assumes aclk from the bench; go is one cycle, n above zero.
`default_nettype none
module tcu_pin_src (
  input wire logic aclk,
  input wire logic go,
  input wire logic [7:0] n,
  output logic pin,
  output logic busy
);
  logic [8:0] left_r;
  initial begin
    left_r = 9'h000;
    pin = 1'h0;
  end
  // each level held one full cycle, high then low
  always @(posedge aclk) begin
    if (go && left_r == 9'h000) begin
      left_r <= {n, 1'h0};
    end else if (left_r != 9'h000) begin
      pin <= ~left_r[0];
      left_r <= left_r - 9'h001;
    end
  end
  assign busy = (left_r != 9'h000);
endmodule
`default_nettype wire

/* File: verif/tcu_timer_unit_bench.sv */
// tcu_timer_unit_bench: self-checking bench of the timer unit.
// assumes tcu_pkg and tcu_pin_src are compiled first.
`default_nettype none
module tcu_timer_unit_bench;
  timeunit 1ns;
  timeprecision 1ns;
  import tcu_pkg::*;
  logic aclk, aresetn, go, busy, p0, ck1, ck2, g0, ack0, f0, f1, irq;
  logic awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [1:0] bresp, rresp;
  logic [7:0] n, k;
  logic [15:0] lf;
  logic [33:0] q[$];
  logic [33:0] e, s;
  logic ack1;
  int failures, num_checks, cyc;

  tcu_timer_unit u_tcu_timer_unit (.aclk(aclk), .aresetn(aresetn),
    .count_input_zero(p0), .count_input_one(ck1), .count_input_two(ck2),
    .ext_irq_zero_pin(g0), .ext_irq_one_pin(ck2),
    .timer_zero_vector_ack(ack0), .timer_one_vector_ack(ack1),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .timer_zero_overflow_flag(f0),
    .timer_one_overflow_flag(f1), .irq(irq));
  tcu_pin_src u_tcu_pin_src (.aclk(aclk), .go(go), .n(n), .pin(p0),
    .busy(busy));

  // ----------------------------------------------------------
  // clock, random pins, hang guard, read and write response checker
  // ----------------------------------------------------------
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  initial begin
    aclk = 1'h0;
    forever #20 aclk = ~aclk;
  end
  always @(posedge aclk) begin
    lf <= lfsr(lf);
    ck1 <= lf[0] & lf[3];
    ck2 <= lf[1];
    cyc = cyc + 1;
    if (cyc == 20000) begin
      failures = failures + 1;
      give_verdict();
    end
  end
  // oldest queued note against each read or write answer
  always @(posedge aclk) begin
    if ((rvalid && rready) || (bvalid && bready)) begin
      s = rvalid ? {rresp, rdata} : {bresp, 32'h0};
      e = q.pop_front();
      num_checks = num_checks + 1;
      if (s !== e) begin
        failures = failures + 1;
        $display("[FAIL] response exp %h got %h", e, s);
      end
    end
  end

  // ----------------------------------------------------------
  // bus and pulse tasks
  // ----------------------------------------------------------
  function automatic logic [11:0] a(input logic [7:0] i);
    return {2'h0, i, 2'h0};
  endfunction
  task automatic wr(input logic [11:0] ad, input logic [7:0] d);
    q.push_back({RESP_OKAY, 32'h0});
    @(posedge aclk);
    awaddr <= ad;
    wdata <= {24'h0, d};
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    do begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'h0;
      if (wvalid && wready) wvalid <= 1'h0;
    end while (!bvalid);
    bready <= 1'h0;
  endtask
  task automatic rd(input logic [11:0] ad, input logic [1:0] r,
                    input logic [7:0] d);
    q.push_back({r, 24'h0, d});
    @(posedge aclk);
    araddr <= ad;
    arvalid <= 1'h1;
    rready <= 1'h1;
    do begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'h0;
    end while (!rvalid);
    rready <= 1'h0;
  endtask
  task automatic pulse(input logic [7:0] c);
    @(posedge aclk);
    n <= c;
    go <= 1'h1;
    @(posedge aclk);
    go <= 1'h0;
    do @(posedge aclk); while (busy);
    repeat (4) @(posedge aclk);
  endtask
  task automatic chk(input logic v, input logic x, input string s);
    num_checks = num_checks + 1;
    if (v !== x) begin
      failures = failures + 1;
      $display("[FAIL] %s exp %b got %b", s, x, v);
    end
  endtask
  task automatic give_verdict();
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  // ----------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------
  initial begin
    aresetn = 1'h0; go = 1'h0; n = 8'h00; g0 = 1'h0; ack0 = 1'h0;
    awvalid = 1'h0; wvalid = 1'h0; bready = 1'h0; arvalid = 1'h0;
    rready = 1'h0; awaddr = 12'h000; araddr = 12'h000;
    wdata = 32'h0; lf = 16'hE8D1; ck1 = 1'h0; ck2 = 1'h0;
    failures = 0; num_checks = 0; cyc = 0; ack1 = 1'h0;
    repeat (6) @(posedge aclk);
    aresetn <= 1'h1;
    rd(a(IDX_CTL), RESP_OKAY, 8'h00);
    rd(a(IDX_MOD), RESP_OKAY, 8'h00);
    $display("test reset values done");
    wr(a(IDX_MOD), 8'h0D);
    wr(a(IDX_HI[0]), 8'h00);
    wr(a(IDX_LO[0]), 8'h00);
    wr(a(IDX_CTL), 8'h10);
    k = {3'h0, lf[4:0]} + 8'h01;
    pulse(k);
    rd(a(IDX_LO[0]), RESP_OKAY, 8'h00);
    g0 <= 1'h1;
    pulse(k);
    rd(a(IDX_LO[0]), RESP_OKAY, k);
    $display("test gated edge count done");
    wr(a(IDX_MOD), 8'h06);
    wr(a(IDX_HI[0]), 8'hAB);
    wr(a(IDX_LO[0]), 8'hFE);
    wr(a(IDX_MASK), 8'h01);
    pulse(8'h02);
    rd(a(IDX_LO[0]), RESP_OKAY, 8'hAB);
    chk(f0, 1'h1, "overflow flag");
    chk(irq, 1'h1, "irq");
    @(posedge aclk);
    ack0 <= 1'h1;
    @(posedge aclk);
    ack0 <= 1'h0;
    @(posedge aclk);
    chk(f0, 1'h0, "flag after ack");
    wr(a(IDX_STAT), 8'h01);
    @(posedge aclk);
    chk(irq, 1'h0, "irq after clear");
    $display("test reload and overflow done");
    wr(a(IDX_MOD), 8'h30);
    wr(a(IDX_LO[1]), 8'h5A);
    wr(a(IDX_CTL), 8'h50);
    repeat (20) @(posedge aclk);
    rd(a(IDX_LO[1]), RESP_OKAY, 8'h5A);
    wr(12'h638, 8'h00);
    rd(a(IDX_CTL), RESP_OKAY, 8'h10);
    rd(12'h630, RESP_OKAY, 8'h01);
    rd(a(8'h00), RESP_SLVERR, 8'h00);
    $display("test hold, bit access, unmapped done");
    wr(a(IDX_MOD), 8'h01);
    wr(a(IDX_HI[0]), 8'hFF);
    wr(a(IDX_LO[0]), 8'hF0);
    repeat (20) @(posedge aclk);
    chk(f0, 1'h1, "16-bit overflow flag");
    wr(a(IDX_MOD), 8'h03);
    wr(a(IDX_HI[0]), 8'hF0);
    wr(a(IDX_CTL), 8'h50);
    repeat (20) @(posedge aclk);
    chk(f1, 1'h1, "split overflow flag");
    @(posedge aclk);
    ack1 <= 1'h1;
    @(posedge aclk);
    ack1 <= 1'h0;
    @(posedge aclk);
    chk(f1, 1'h0, "flag one after ack");
    wr(a(IDX_LO[2]), 8'hFF);
    wr(a(IDX_HI[2]), 8'hFF);
    wr(a(IDX_CAP_LO), 8'h34);
    wr(a(IDX_CAP_HI), 8'h12);
    wr(a(IDX_T2C), 8'h04);
    rd(a(IDX_HI[2]), RESP_OKAY, 8'h12);
    rd(a(IDX_T2C), RESP_OKAY, 8'h84);
    $display("test cascade, split, channel two done");
    give_verdict();
  end
endmodule
`default_nettype wire
